// file: core/pwmg_tick_gen.sv
`timescale 1ns/1ps
`include "pwmg_consts.svh"

module pwmg_tick_gen #(
	parameter int SYS_KHZ  = `PWMG_SYS_KHZ,
	parameter int BASE_KHZ = `PWMG_BASE_KHZ
) (
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                run,
	input  wire pwmg_pkg::pwmg_sel_t sel,
	output logic                     tick
);
	import pwmg_pkg::*;

	localparam int ACC_W = $clog2(SYS_KHZ) + 1;

	// rates the accumulator cannot serve stop elaboration
	if (BASE_KHZ <= 0 || BASE_KHZ > SYS_KHZ)
	begin : g_bad_rate
		$error("pwmg_tick_gen: base rate must lie in (0, system rate]");
	end

	// ==========================================================
	// fractional base rate: phase accumulator
	// jitter of one system cycle is traded for exact average rate
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W:0]   acc_sum;
	logic             base_tick;
	logic [6:0]       div_q;

	assign acc_sum   = {1'b0, acc_q} + (ACC_W+1)'(BASE_KHZ);
	assign base_tick = run && (acc_sum >= (ACC_W+1)'(SYS_KHZ));

	always_ff @(posedge clock)
	begin
		if (rst || !run)
			acc_q <= '0;
		else if (base_tick)
			acc_q <= ACC_W'(acc_sum - (ACC_W+1)'(SYS_KHZ));
		else
			acc_q <= acc_sum[ACC_W-1:0];
	end

	// ==========================================================
	// binary divider: code n divides base rate by 2^n
	function automatic logic [6:0] div_last(input pwmg_sel_t s);
		div_last = 7'((8'h01 << s) - 8'h01);
	endfunction

	always_ff @(posedge clock)
	begin
		if (rst || !run)
			div_q <= '0;
		else if (base_tick)
			div_q <= (div_q >= div_last(sel)) ? 7'h00 : div_q + 7'h01;
	end

	assign tick = base_tick && (div_q >= div_last(sel));

endmodule // pwmg_tick_gen

// file: core/pwmg_unit.sv
// Notes on behaviour
// RULE_01: the upper half of the phase register holds a read-write high count in prescaled ticks.
// RULE_02: the lower half of the phase register holds a read-write low count in prescaled ticks.
// RULE_03: a 3-bit select picks the counting rate, 48 MHz at code 0, halving per code to 0.375 MHz.
// RULE_04: the generator runs only while the enable bit of the config register is one.
// RULE_05: the status flag becomes one when a period completes and reads zero before that.
// RULE_06: software writes to the flag bit position have no effect on the flag.
// RULE_07: writing one to the clear bit, or a reset, clears the flag; the clear bit stores nothing.
// RULE_08: switching the enable bit off also clears the flag.
// RULE_09: the interrupt line is high only when the interrupt enable and the flag are both set.
// RULE_10: the clear bit always reads back as zero.
// RULE_11: while enabled the output is high for the high count, then low for the low count, repeating.
// RULE_12: disabling stops and clears the phase counter; re-enabling starts again at the high phase.
`timescale 1ns/1ps
`include "pwmg_consts.svh"

module pwmg_unit (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic [`PWMG_ADDR_W-1:0]     reg_addr,
	input  wire pwmg_pkg::pwmg_word_t        reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output pwmg_pkg::pwmg_word_t             reg_rdata,
	output logic                             pwm_out,
	output logic                             irq
);
	import pwmg_pkg::*;

	// ==========================================================
	// register decode
	logic wr_phase;
	logic wr_cfg;
	logic wr_irq;

	assign wr_phase = reg_wr && (reg_addr == `PWMG_OFF_PHASE);
	assign wr_cfg   = reg_wr && (reg_addr == `PWMG_OFF_CFG);
	assign wr_irq   = reg_wr && (reg_addr == `PWMG_OFF_IRQ);

	// ==========================================================
	// phase counts
	pwmg_count_t high_q;
	pwmg_count_t low_q;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			high_q <= `PWMG_RST_CNT;
			low_q  <= `PWMG_RST_CNT;
		end
		else if (wr_phase)
		begin
			high_q <= reg_wdata[`PWMG_HIGH_MSB:`PWMG_HIGH_LSB]; // RULE_01
			low_q  <= reg_wdata[`PWMG_LOW_MSB:`PWMG_LOW_LSB];   // RULE_02
		end
	end

	// ==========================================================
	// configuration: enable and rate select
	logic      en_q;
	pwmg_sel_t sel_q;
	logic      turn_off;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			en_q  <= `PWMG_RST_BIT;
			sel_q <= `PWMG_RST_SEL;
		end
		else if (wr_cfg)
		begin
			en_q  <= reg_wdata[`PWMG_EN_BIT];
			sel_q <= reg_wdata[`PWMG_SEL_MSB:`PWMG_SEL_LSB]; // RULE_03
		end
	end

	// any config write with the enable bit low counts as turning off
	assign turn_off = wr_cfg && !reg_wdata[`PWMG_EN_BIT];

	// ==========================================================
	// counting clock enable
	logic tick;

	pwmg_tick_gen #(
		.SYS_KHZ  (`PWMG_SYS_KHZ),
		.BASE_KHZ (`PWMG_BASE_KHZ)
	) u_tick (
		.clock (clock),
		.rst   (rst),
		.run   (en_q),
		.sel   (sel_q),
		.tick  (tick)
	);

	// ==========================================================
	// phase sequencer
	// a zero count still lasts one tick, so the output never stalls
	pwmg_state_t state_q;
	pwmg_state_t state_d;
	pwmg_count_t cnt_q;
	pwmg_count_t cnt_d;
	logic        phase_done;
	logic        period_end;
	logic        out_q;

	function automatic logic last_tick(input pwmg_count_t cnt, input pwmg_count_t lim);
		last_tick = ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
	endfunction

	assign phase_done = tick && last_tick(cnt_q, (state_q == PWMG_S_HIGH) ? high_q : low_q);
	assign period_end = phase_done && (state_q == PWMG_S_LOW);

	// next state and count
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (!en_q)
		begin
			state_d = PWMG_S_IDLE; // RULE_04
			cnt_d   = `PWMG_RST_CNT; // RULE_12
		end
		else
		begin
			unique case (state_q)
				PWMG_S_IDLE:
				begin
					state_d = PWMG_S_HIGH; // RULE_12
					cnt_d   = `PWMG_RST_CNT;
				end
				PWMG_S_HIGH:
				begin
					if (phase_done)
					begin
						state_d = PWMG_S_LOW; // RULE_11
						cnt_d   = `PWMG_RST_CNT;
					end
					else if (tick)
						cnt_d = cnt_q + 16'h0001;
				end
				PWMG_S_LOW:
				begin
					if (phase_done)
					begin
						state_d = PWMG_S_HIGH; // RULE_11
						cnt_d   = `PWMG_RST_CNT;
					end
					else if (tick)
						cnt_d = cnt_q + 16'h0001;
				end
				default:
				begin
					state_d = PWMG_S_IDLE;
					cnt_d   = `PWMG_RST_CNT;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_q <= PWMG_S_IDLE;
			cnt_q   <= `PWMG_RST_CNT;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// output pin straight from a flop
	always_ff @(posedge clock)
	begin
		if (rst)
			out_q <= `PWMG_RST_BIT;
		else
			out_q <= (state_d == PWMG_S_HIGH); // RULE_11
	end

	assign pwm_out = out_q;

	// ==========================================================
	// interrupt flag and enable
	logic flag_q;
	logic ien_q;
	logic flag_clr;

	assign flag_clr = (wr_irq && reg_wdata[`PWMG_CLR_BIT]) || turn_off; // RULE_07 RULE_08

	// set beats clear so a period end is never lost
	always_ff @(posedge clock)
	begin
		if (rst)
			flag_q <= `PWMG_RST_BIT; // RULE_07
		else if (period_end)
			flag_q <= 1'b1; // RULE_05
		else if (flag_clr)
			flag_q <= 1'b0; // RULE_07 RULE_08
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			ien_q <= `PWMG_RST_BIT;
		else if (wr_irq)
			ien_q <= reg_wdata[`PWMG_IEN_BIT];
	end

	assign irq = ien_q && flag_q; // RULE_09

	// ==========================================================
	// read port: data one cycle after the strobe, zero elsewhere
	pwmg_word_t rd_mux;

	always_comb
	begin
		rd_mux = '0;
		unique case (reg_addr)
			`PWMG_OFF_PHASE:
			begin
				rd_mux[`PWMG_HIGH_MSB:`PWMG_HIGH_LSB] = high_q;
				rd_mux[`PWMG_LOW_MSB:`PWMG_LOW_LSB]   = low_q;
			end
			`PWMG_OFF_CFG:
			begin
				rd_mux[`PWMG_EN_BIT]                = en_q;
				rd_mux[`PWMG_SEL_MSB:`PWMG_SEL_LSB] = sel_q;
			end
			`PWMG_OFF_IRQ:
			begin
				rd_mux[`PWMG_IEN_BIT]  = ien_q;
				rd_mux[`PWMG_FLAG_BIT] = flag_q;
				rd_mux[`PWMG_CLR_BIT]  = 1'b0; // RULE_10
			end
			default:
				rd_mux = '0;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= '0;
	end

	// ==========================================================
	// checks
	sequence s_phase_write;
		wr_phase;
	endsequence

	sequence s_enable_rise;
		!en_q ##1 en_q;
	endsequence

	property p_high_store;
		@(posedge clock) disable iff (rst)
		s_phase_write |=> (high_q == $past(reg_wdata[`PWMG_HIGH_MSB:`PWMG_HIGH_LSB]));
	endproperty
	a_high_store: assert property (p_high_store) else $error("high count not stored"); // RULE_01

	property p_low_store;
		@(posedge clock) disable iff (rst)
		s_phase_write |=> (low_q == $past(reg_wdata[`PWMG_LOW_MSB:`PWMG_LOW_LSB]));
	endproperty
	a_low_store: assert property (p_low_store) else $error("low count not stored"); // RULE_02

	property p_slow_rate;
		@(posedge clock) disable iff (rst)
		(tick && sel_q >= 3'h3 && !wr_cfg) |=> !tick [*8];
	endproperty
	a_slow_rate: assert property (p_slow_rate) else $error("divided tick too fast"); // RULE_03

	property p_disabled_idle;
		@(posedge clock) disable iff (rst)
		!en_q |=> (state_q == PWMG_S_IDLE) && !pwm_out && !tick;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("runs while disabled"); // RULE_04

	property p_flag_set;
		@(posedge clock) disable iff (rst)
		period_end |=> flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("period end not flagged"); // RULE_05

	property p_flag_no_write;
		@(posedge clock) disable iff (rst)
		(!flag_q && !period_end && wr_irq) |=> !flag_q;
	endproperty
	a_flag_no_write: assert property (p_flag_no_write) else $error("flag set by write"); // RULE_06

	// the flag may only fall through one of the listed clears
	property p_flag_sticky;
		@(posedge clock) disable iff (rst)
		(flag_q && !flag_clr) |=> flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped on its own"); // RULE_06

	property p_flag_clear;
		@(posedge clock) disable iff (rst)
		(wr_irq && reg_wdata[`PWMG_CLR_BIT] && !period_end) |=> !flag_q && !irq;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("clear bit ignored"); // RULE_07

	property p_off_clear;
		@(posedge clock) disable iff (rst)
		(turn_off && !period_end) |=> !flag_q ##1 !flag_q;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("disable kept flag"); // RULE_08

	property p_irq_gate;
		@(posedge clock) disable iff (rst)
		(flag_q && !ien_q) |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable"); // RULE_09

	property p_clr_reads_zero;
		@(posedge clock) disable iff (rst)
		(reg_rd && reg_addr == `PWMG_OFF_IRQ) |=> !reg_rdata[`PWMG_CLR_BIT];
	endproperty
	a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("clear bit read back"); // RULE_10

	property p_high_to_low;
		@(posedge clock) disable iff (rst)
		(en_q && state_q == PWMG_S_HIGH && phase_done && !wr_cfg) |=> !pwm_out;
	endproperty
	a_high_to_low: assert property (p_high_to_low) else $error("high phase overran"); // RULE_11

	// end of the low phase must hand straight back to the high phase
	property p_low_to_high;
		@(posedge clock) disable iff (rst)
		(en_q && state_q == PWMG_S_LOW && phase_done && !wr_cfg) |=> pwm_out;
	endproperty
	a_low_to_high: assert property (p_low_to_high) else $error("low phase overran"); // RULE_11

	property p_restart_high;
		@(posedge clock) disable iff (rst)
		s_enable_rise |=> (state_q == PWMG_S_HIGH) && (cnt_q == `PWMG_RST_CNT) && pwm_out;
	endproperty
	a_restart_high: assert property (p_restart_high) else $error("no restart at high"); // RULE_12

endmodule // pwmg_unit

// file: inc/pwmg_consts.svh
`ifndef PWMG_CONSTS_SVH
`define PWMG_CONSTS_SVH

// ==========================================================
// register map (byte offsets)
`define PWMG_ADDR_W       8
`define PWMG_OFF_PHASE    8'h00
`define PWMG_OFF_CFG      8'h04
`define PWMG_OFF_IRQ      8'h08

// ==========================================================
// field positions
`define PWMG_HIGH_MSB     31
`define PWMG_HIGH_LSB     16
`define PWMG_LOW_MSB      15
`define PWMG_LOW_LSB      0
`define PWMG_EN_BIT       0
`define PWMG_SEL_MSB      3
`define PWMG_SEL_LSB      1
`define PWMG_IEN_BIT      0
`define PWMG_FLAG_BIT     1
`define PWMG_CLR_BIT      2

// ==========================================================
// reset values
`define PWMG_RST_PHASE    32'h0000_0000
`define PWMG_RST_SEL      3'h0
`define PWMG_RST_BIT      1'h0
`define PWMG_RST_CNT      16'h0000

// ==========================================================
// clock rates in kHz
`define PWMG_SYS_KHZ      100000
`define PWMG_BASE_KHZ     48000

`endif

// file: inc/pwmg_pkg.sv
package pwmg_pkg;

	// one-hot phase states
	typedef enum logic [2:0]
	{
		PWMG_S_IDLE = 3'h1,
		PWMG_S_HIGH = 3'h2,
		PWMG_S_LOW  = 3'h4
	} pwmg_state_t;

	typedef logic [2:0]  pwmg_sel_t;
	typedef logic [15:0] pwmg_count_t;
	typedef logic [31:0] pwmg_word_t;

endpackage

// file: test/pwmg_load_model.sv
`timescale 1ns/1ps

// ==========================================================
// external load: measures each level's width in system cycles
module pwmg_load_model (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic pwm_out,
	output int        hi_len,
	output int        lo_len
);
	logic prev_q;
	int   cnt_q;

	// width stored at each edge; idle time before enable lands in lo_len
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prev_q <= 1'h0;
			cnt_q  <= 0;
			hi_len <= 0;
			lo_len <= 0;
		end
		else if (pwm_out != prev_q)
		begin
			prev_q <= pwm_out;
			cnt_q  <= 1;
			if (prev_q)
				hi_len <= cnt_q;
			else
				lo_len <= cnt_q;
		end
		else
			cnt_q <= cnt_q + 1;
	end
endmodule // pwmg_load_model

// file: test/pwmg_unit_tb.sv
`timescale 1ns/1ps
`include "pwmg_consts.svh"

// ==========================================================
// bench for one pulse unit and its load
module pwmg_unit_tb;
	typedef struct {int h; int l; int sel;} pwmg_row_t;

	logic                 clock;
	logic                 rst;
	logic [7:0]           reg_addr;
	pwmg_pkg::pwmg_word_t reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	pwmg_pkg::pwmg_word_t reg_rdata;
	logic                 pwm_out;
	logic                 irq;
	int                   hi_len;
	int                   lo_len;
	int                   err_total = 0;
	int                   n_checks = 0;
	int                   cyc = 0;
	pwmg_row_t            rows [8] = '{'{3,5,0}, '{4,2,1}, '{1,1,2}, '{0,2,3},
		'{1,2,4}, '{2,1,5}, '{1,1,6}, '{2,3,7}};

	pwmg_unit pwmg_unit_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pwm_out(pwm_out), .irq(irq));
	pwmg_load_model pwmg_load_model_inst (.clock(clock), .rst(rst),
		.pwm_out(pwm_out), .hi_len(hi_len), .lo_len(lo_len));

	// ==========================================================
	// tasks
	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask

	// tick spacing jitters, so widths get a few cycles of slack
	task automatic chk_near(input int g, input int e);
		n_checks++;
		if (g < e - 3 || g > e + 3)
		begin
			err_total++;
			$display("ERROR %0t: width %0d want %0d", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata, e);
	endtask

	// zero count behaves as one tick; 48 ticks per 100 cycles
	function automatic int ecyc(input int n, input int s);
		return (((n < 1) ? 1 : n) * (1 << s) * 100 + 24) / 48;
	endfunction

	// ==========================================================
	// clock and hang guard
	initial
	begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			$display("ERROR %0t: timeout", $time);
			results();
		end
	end

	// ==========================================================
	// main sequence
	initial
	begin
		rst       = 1'h1;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr    = 1'h0;
		reg_rd    = 1'h0;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		for (int a = 0; a < 16; a += 4)
			chkrd(a[7:0], 32'h0000_0000);
		$display("reset values done");
		foreach (rows[i])
		begin
			wr(`PWMG_OFF_PHASE, {rows[i].h[15:0], rows[i].l[15:0]});
			wr(`PWMG_OFF_CFG, {28'h0, rows[i].sel[2:0], 1'h1});
			repeat (2) @(posedge pwm_out);
			@(negedge pwm_out);
			@(posedge pwm_out);
			repeat (2) @(posedge clock);
			chk_near(hi_len, ecyc(rows[i].h, rows[i].sel));
			chk_near(lo_len, ecyc(rows[i].l, rows[i].sel));
			chkrd(`PWMG_OFF_IRQ, 32'h0000_0002);
			chk({31'h0, irq}, 32'h0);
			wr(`PWMG_OFF_CFG, 32'h0000_0000);
			chkrd(`PWMG_OFF_IRQ, 32'h0000_0000);
			chk({31'h0, pwm_out}, 32'h0);
			$display("row %0d done", i);
		end
		wr(`PWMG_OFF_IRQ, 32'h0000_0002);
		chkrd(`PWMG_OFF_IRQ, 32'h0000_0000);
		wr(`PWMG_OFF_PHASE, 32'h0064_0032);
		chkrd(`PWMG_OFF_PHASE, 32'h0064_0032);
		wr(`PWMG_OFF_CFG, 32'h0000_000E);
		chkrd(`PWMG_OFF_CFG, 32'h0000_000E);
		repeat (20) @(posedge clock);
		chk({31'h0, pwm_out}, 32'h0);
		$display("register access done");
		wr(`PWMG_OFF_IRQ, 32'h0000_0001);
		wr(`PWMG_OFF_CFG, 32'h0000_0001);
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, pwm_out}, 32'h1);
		@(negedge pwm_out);
		@(posedge pwm_out);
		repeat (2) @(posedge clock);
		chkrd(`PWMG_OFF_IRQ, 32'h0000_0003);
		chk({31'h0, irq}, 32'h1);
		@(posedge clock);
		#1;
		chk(reg_rdata, 32'h0000_0000);
		wr(`PWMG_OFF_IRQ, 32'h0000_0005);
		chkrd(`PWMG_OFF_IRQ, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0);
		@(posedge pwm_out);
		repeat (2) @(posedge clock);
		wr(`PWMG_OFF_IRQ, 32'h0000_0000);
		chkrd(`PWMG_OFF_IRQ, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0);
		$display("interrupt done");
		@(posedge clock);
		rst <= 1'h1;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		chkrd(`PWMG_OFF_IRQ, 32'h0000_0000);
		chkrd(`PWMG_OFF_CFG, 32'h0000_0000);
		chkrd(`PWMG_OFF_PHASE, 32'h0000_0000);
		chk({31'h0, pwm_out}, 32'h0);
		$display("mid-run reset done");
		results();
	end
endmodule // pwmg_unit_tb
